/* File: core/boot_mode_regs.vh */
`ifndef BOOT_MODE_REGS_VH
`define BOOT_MODE_REGS_VH

// Strap and source encodings
`define BOOT_SEL_W 4
`define BOOT_DEV_MSB 2
`define BSRC_FUSE 3'h0
`define BSRC_USB 3'h1
`define BSRC_EMMC 3'h2
`define BSRC_SD 3'h3
`define BSRC_NOR 3'h4
`define BSRC_NAND 3'h5

// Pad mux function codes, idle means the boot logic leaves the pad alone
`define PAD_FUNC_ZERO 3'h0
`define PAD_FUNC_TWO 3'h2
`define PAD_FUNC_IDLE 3'h7
`define PAD_FUNC_W 3

// Boot interfaces that may own pads
`define IF_NONE 3'h0
`define IF_FLASH 3'h1
`define IF_SD1_EMMC 3'h2
`define IF_SD1_SD 3'h3
`define IF_SD2 3'h4
`define IF_FIRST_RECOVERY_SERIAL_PORT 3'h5
`define IF_SECOND_RECOVERY_SERIAL_PORT 3'h6

// Flash data width codes
`define FW_1BIT 2'h0
`define FW_4BIT 2'h1
`define FW_8BIT 2'h2

// Pad counts per group
`define FLASH_PADS 12
`define SD1_PADS 10
`define SD2_PADS 8
`define SPI_PADS 5
`define SD1_D5_IDX 7
`define SD1_SD_PADS 6

// Strap settling time after reset release
`define STRAP_SETTLE_NS 40
`define CLK_PERIOD_NS 10
`define SETTLE_CYC ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W 3

`endif

/* File: core/strap_sync.v */
`timescale 1ns/1ps
`default_nettype none

module strap_sync (
   // Clock and reset
   input wire i_core_clk,
   input wire i_nrst,
   // Asynchronous strap levels
   input wire [3:0] i_async,
   // Synchronised levels
   output wire [3:0] o_sync
);

   reg [3:0] meta_q;
   reg [3:0] sync_q;

   // Two stages; only the second stage is read outside
   always @(posedge i_core_clk) begin
      if (!i_nrst) begin
         meta_q <= 4'h0;
         sync_q <= 4'h0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule

`default_nettype wire

/* File: core/boot_pad_mux.v */
`timescale 1ns/1ps
`default_nettype none
`include "boot_mode_regs.vh"

module boot_pad_mux (
   // Selection
   input wire [2:0] i_iface,
   input wire [1:0] i_flash_width,
   input wire i_sd1_reset_on_d5,
   // Per-pad function codes, pad 0 in the low bits
   output wire [35:0] o_flash_func,
   output wire [29:0] o_sd1_func,
   output wire [23:0] o_sd2_func,
   output wire [14:0] o_first_recovery_serial_port_func,
   output wire [14:0] o_second_recovery_serial_port_func
);

   // Flash pads: data0..7, strobe, two selects, clock; unused data lanes stay idle
   function flash_pad_used;
      input integer k;
      input [1:0] w;
      begin
         flash_pad_used = (k > 7) || (k < 2) || ((k < 4) && (w != `FW_1BIT))
            || (w == `FW_8BIT);
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < `FLASH_PADS; g = g + 1) begin : g_flash
         assign o_flash_func[g*3 +: 3] = ((i_iface == `IF_FLASH) && flash_pad_used(g, i_flash_width))
            ? `PAD_FUNC_ZERO : `PAD_FUNC_IDLE; // R16
      end
      // Host 1 pads: cmd, clk, data0..7; SD uses only four data lanes
      for (g = 0; g < `SD1_PADS; g = g + 1) begin : g_sd1
         assign o_sd1_func[g*3 +: 3] =
            ((i_iface == `IF_SD1_EMMC) && (g == `SD1_D5_IDX) && i_sd1_reset_on_d5) ? `PAD_FUNC_TWO :
            ((i_iface == `IF_SD1_EMMC) || ((i_iface == `IF_SD1_SD) && (g < `SD1_SD_PADS)))
            ? `PAD_FUNC_ZERO : `PAD_FUNC_IDLE; // R17
      end
      // Host 2 pads: cmd, clk, data0..3, card reset, voltage select
      for (g = 0; g < `SD2_PADS; g = g + 1) begin : g_sd2
         assign o_sd2_func[g*3 +: 3] = (i_iface == `IF_SD2) ? `PAD_FUNC_ZERO : `PAD_FUNC_IDLE; // R18
      end
      // Recovery ports: select1, data in, data out, clock, select0
      for (g = 0; g < `SPI_PADS; g = g + 1) begin : g_spi
         assign o_first_recovery_serial_port_func[g*3 +: 3] = (i_iface == `IF_FIRST_RECOVERY_SERIAL_PORT) ? `PAD_FUNC_TWO : `PAD_FUNC_IDLE; // R19
         assign o_second_recovery_serial_port_func[g*3 +: 3] = (i_iface == `IF_SECOND_RECOVERY_SERIAL_PORT) ? `PAD_FUNC_TWO : `PAD_FUNC_IDLE; // R20
      end
   endgenerate

endmodule

`default_nettype wire

/* File: core/boot_mode_select.v */
`timescale 1ns/1ps
`default_nettype none
`include "boot_mode_regs.vh"

// Notes on behaviour
// R1: Four strap bits taken; top bit ignored; low codes 110 and 111 reserved.
// R2: Low strap bits 000 means configuration comes from fuses.
// R3: Code 001 enters serial download over USB; no pad muxing needed.
// R4: Code 010 boots 8-bit eMMC, only on first card host.
// R5: Code 011 boots 4-bit SD on first or second card host.
// R6: Code 100 boots serial NOR with 1, 4 or 8 bit width.
// R7: Code 101 boots serial NAND with 1, 4 or 8 bit width.
// R8: Straps sampled before ROM starts; pads default to strap function.
// R9: Sampled configuration stored and held in the latch register.
// R10: Normal, fuse and download modes; fuses may override the straps.
// R11: Primary device from fuses in fuse mode, else from straps.
// R12: Primary failure falls back to recovery on first or second SPI.
// R13: Low-power boot type; only the safety core runs after reset.
// R14: Board must not drive shared strap inputs during power-on reset.
// R15: Board must not treat shared outputs toggling in reset as valid.
// R16: Flash boot puts flash pad group on function zero; the code leaves data lanes unused at 1 or 4 bit width idle.
// R17: First host boot uses function zero; card reset on data5, function two.
// R18: Second host boot puts all its pads on function zero.
// R19: First recovery port routed to audio and PDM pads, function two.
// R20: Second recovery port routed to UART and PDM pads, function two.
// R21: Pad muxing for the chosen interface set automatically during boot.
// R22: Configuration captured once after reset release, then never changes.
module boot_mode_select (
   // Clock and power-on reset
   input wire i_core_clk,
   input wire i_nrst,
   // Strap pins
   input wire [3:0] i_boot_mode_pin,
   // Fuse values, same clock domain
   input wire i_fuse_override,
   input wire [2:0] i_fuse_boot_dev,
   input wire i_fuse_sd_on_host1,
   input wire i_fuse_sd1_reset_on_d5,
   input wire [1:0] i_fuse_flash_width,
   input wire i_fuse_recovery_port,
   // Boot ROM status pulses
   input wire i_primary_fail,
   input wire i_recovery_fail,
   // Latched configuration and decode
   output reg [3:0] o_boot_cfg_q,
   output reg o_cfg_valid_q,
   output reg o_fuse_mode_q,
   output reg [2:0] o_boot_dev_q,
   output reg [1:0] o_flash_width_q,
   output reg o_download_mode_q,
   output reg o_recovery_q,
   output reg o_recovery_port_q,
   output reg o_boot_error_q,
   // Boot sequencing
   output reg o_strap_pads_boot_fn_q,
   output reg o_rom_start_q,
   output reg o_safety_core_run_q,
   output reg o_low_power_boot_type_q,
   // Pad mux function codes
   output reg [35:0] o_flash_func_q,
   output reg [29:0] o_sd1_func_q,
   output reg [23:0] o_sd2_func_q,
   output reg [14:0] o_first_recovery_serial_port_func_q,
   output reg [14:0] o_second_recovery_serial_port_func_q
);

   // Sequencer states
   localparam [2:0] ST_SETTLE = 3'h0;
   localparam [2:0] ST_DECODE = 3'h1;
   localparam [2:0] ST_PRIMARY = 3'h2;
   localparam [2:0] ST_RECOVER = 3'h3;
   localparam [2:0] ST_DOWNLOAD = 3'h4;
   localparam [2:0] ST_HALT = 3'h5;

   // Integer first, then cut to the counter width on purpose
   localparam integer SETTLE_LAST_I = `SETTLE_CYC - 1;
   localparam [`SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_LAST_I[`SETTLE_CNT_W-1:0];

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [`SETTLE_CNT_W-1:0] settle_cnt_q;
   reg [2:0] iface_q;
   reg [2:0] iface_d;
   reg captured_q;

   wire [3:0] strap_sync_w;
   wire [35:0] flash_func_w;
   wire [29:0] sd1_func_w;
   wire [23:0] sd2_func_w;
   wire [14:0] first_recovery_serial_port_func_w;
   wire [14:0] second_recovery_serial_port_func_w;

   // Decode results, looked at only in the decode state
   wire fuse_mode_w;
   wire [2:0] dev_w;
   wire dev_primary_w;
   wire dev_download_w;

   // True for devices that may serve as primary boot source
   function is_primary;
      input [2:0] dev;
      begin
         is_primary = (dev == `BSRC_EMMC) || (dev == `BSRC_SD) ||
            (dev == `BSRC_NOR) || (dev == `BSRC_NAND);
      end
   endfunction

   // Choose the boot source from straps or fuses
   function [2:0] pick_dev;
      input [3:0] cfg;
      input use_fuse;
      input [2:0] fuse_dev;
      begin
         if (use_fuse) begin
            pick_dev = fuse_dev;
         end else begin
            pick_dev = cfg[`BOOT_DEV_MSB:0];
         end
      end
   endfunction

   // Map a primary device onto the interface whose pads it needs
   function [2:0] primary_iface;
      input [2:0] dev;
      input sd_on_host1;
      begin
         case (dev)
            `BSRC_EMMC: begin
               primary_iface = `IF_SD1_EMMC;
            end
            `BSRC_SD: begin
               primary_iface = sd_on_host1 ? `IF_SD1_SD : `IF_SD2;
            end
            `BSRC_NOR, `BSRC_NAND: begin
               primary_iface = `IF_FLASH;
            end
            default: begin
               primary_iface = `IF_NONE;
            end
         endcase
      end
   endfunction

   // Straps come from pads, so they cross into this clock first
   strap_sync u_strap_sync (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_async(i_boot_mode_pin),
      .o_sync(strap_sync_w)
   );

   // Per-pad function codes for whichever interface owns pads now
   boot_pad_mux u_pad_mux (
      .i_iface(iface_q),
      .i_flash_width(o_flash_width_q),
      .i_sd1_reset_on_d5(i_fuse_sd1_reset_on_d5),
      .o_flash_func(flash_func_w),
      .o_sd1_func(sd1_func_w),
      .o_sd2_func(sd2_func_w),
      .o_first_recovery_serial_port_func(first_recovery_serial_port_func_w),
      .o_second_recovery_serial_port_func(second_recovery_serial_port_func_w)
   );

   // Fuse mode when low strap bits are zero or fuses force it; top bit unused
   assign fuse_mode_w = (o_boot_cfg_q[`BOOT_DEV_MSB:0] == `BSRC_FUSE) || i_fuse_override; // R2 R10
   assign dev_w = pick_dev(o_boot_cfg_q, fuse_mode_w, i_fuse_boot_dev); // R1 R11
   assign dev_primary_w = is_primary(dev_w); // R11
   assign dev_download_w = (dev_w == `BSRC_USB); // R3

   // Next state; reserved codes and bad fuse devices end in halt
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_SETTLE: begin
            if (settle_cnt_q == SETTLE_LAST) begin
               state_d = ST_DECODE;
            end
         end
         ST_DECODE: begin
            if (dev_download_w) begin
               state_d = ST_DOWNLOAD; // R3
            end else if (dev_primary_w) begin
               state_d = ST_PRIMARY; // R4 R5 R6 R7
            end else begin
               state_d = ST_HALT; // R1
            end
         end
         ST_PRIMARY: begin
            if (i_primary_fail) begin
               state_d = ST_RECOVER; // R12
            end
         end
         ST_RECOVER: begin
            if (i_recovery_fail) begin
               state_d = ST_HALT;
            end
         end
         ST_DOWNLOAD: begin
            state_d = ST_DOWNLOAD;
         end
         ST_HALT: begin
            state_d = ST_HALT;
         end
         default: begin
            state_d = ST_HALT;
         end
      endcase
   end

   // Interface owning the pads in the next state; download needs no pads
   always @* begin
      iface_d = `IF_NONE;
      case (state_d)
         ST_PRIMARY: begin
            iface_d = primary_iface(dev_w, i_fuse_sd_on_host1); // R4 R5 R21
         end
         ST_RECOVER: begin
            iface_d = o_recovery_port_q ? `IF_SECOND_RECOVERY_SERIAL_PORT : `IF_FIRST_RECOVERY_SERIAL_PORT; // R12 R21
         end
         default: begin
            iface_d = `IF_NONE; // R3
         end
      endcase
   end

   // Settle counter; runs from reset release, so the synchroniser fills inside the strap settle time
   always @(posedge i_core_clk) begin
      if (!i_nrst) begin
         settle_cnt_q <= {`SETTLE_CNT_W{1'b0}};
      end else if (state_q == ST_SETTLE) begin
         settle_cnt_q <= settle_cnt_q + 1'b1;
      end
   end

   // Sequencer and interface ownership
   always @(posedge i_core_clk) begin
      if (!i_nrst) begin
         state_q <= ST_SETTLE;
         iface_q <= `IF_NONE;
      end else begin
         state_q <= state_d;
         // Owner changes only on a state change; later fuse edits cannot move pads, except the live data5 reset fuse
         if (state_d != state_q) begin
            iface_q <= iface_d; // R21
         end
      end
   end

   // One-shot capture of the straps; nothing later can rewrite it
   always @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_boot_cfg_q <= 4'h0;
         o_cfg_valid_q <= 1'b0;
         captured_q <= 1'b0;
      end else if ((state_q == ST_SETTLE) && (settle_cnt_q == SETTLE_LAST) && !captured_q) begin
         o_boot_cfg_q <= strap_sync_w; // R1 R9 R22
         o_cfg_valid_q <= 1'b1; // R9
         captured_q <= 1'b1; // R22
      end
   end

   // Decode results held from the decode state on
   always @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_fuse_mode_q <= 1'b0;
         o_boot_dev_q <= `BSRC_FUSE;
         o_flash_width_q <= `FW_1BIT;
         o_download_mode_q <= 1'b0;
         o_recovery_port_q <= 1'b0;
      end else if (state_q == ST_DECODE) begin
         o_fuse_mode_q <= fuse_mode_w; // R10
         o_boot_dev_q <= dev_w; // R11
         o_flash_width_q <= i_fuse_flash_width; // R6 R7
         o_download_mode_q <= dev_download_w; // R3
         o_recovery_port_q <= i_fuse_recovery_port; // R12
      end
   end

   // Recovery and error status
   always @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_recovery_q <= 1'b0;
         o_boot_error_q <= 1'b0;
      end else begin
         if (state_d == ST_RECOVER) begin
            o_recovery_q <= 1'b1; // R12
         end
         if ((state_q != ST_HALT) && (state_d == ST_HALT)) begin
            o_boot_error_q <= 1'b1;
         end
      end
   end

   // Pads stay on their strap function until the decode state, one cycle after capture; ROM starts then
   always @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_strap_pads_boot_fn_q <= 1'b1;
         o_rom_start_q <= 1'b0;
         o_safety_core_run_q <= 1'b0;
         o_low_power_boot_type_q <= 1'b0;
      end else begin
         if (state_q == ST_DECODE) begin
            o_strap_pads_boot_fn_q <= 1'b0; // R8
            o_rom_start_q <= 1'b1; // R8
            o_safety_core_run_q <= 1'b1; // R13
         end
         // Only one boot type exists, so it is flagged from the first cycle
         o_low_power_boot_type_q <= 1'b1; // R13
      end
   end

   // Registered pad codes; all idle while straps are being read
   always @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_flash_func_q <= {`FLASH_PADS{`PAD_FUNC_IDLE}};
         o_sd1_func_q <= {`SD1_PADS{`PAD_FUNC_IDLE}};
         o_sd2_func_q <= {`SD2_PADS{`PAD_FUNC_IDLE}};
         o_first_recovery_serial_port_func_q <= {`SPI_PADS{`PAD_FUNC_IDLE}};
         o_second_recovery_serial_port_func_q <= {`SPI_PADS{`PAD_FUNC_IDLE}};
      end else begin
         o_flash_func_q <= flash_func_w; // R16 R21
         o_sd1_func_q <= sd1_func_w; // R17 R21
         o_sd2_func_q <= sd2_func_w; // R18 R21
         o_first_recovery_serial_port_func_q <= first_recovery_serial_port_func_w; // R19 R21
         o_second_recovery_serial_port_func_q <= second_recovery_serial_port_func_w; // R20 R21
      end
   end

endmodule

`default_nettype wire

/* File: test/boot_mode_select_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "boot_mode_regs.vh"
module boot_mode_select_props (
   // Clock, reset and fuse input
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_fuse_override,
   // Latched configuration and decode
   input wire logic [3:0] o_boot_cfg_q,
   input wire logic o_cfg_valid_q,
   input wire logic o_fuse_mode_q,
   input wire logic [2:0] o_boot_dev_q,
   input wire logic o_download_mode_q,
   input wire logic o_recovery_q,
   input wire logic o_recovery_port_q,
   input wire logic o_boot_error_q,
   // Sequencing
   input wire logic o_strap_pads_boot_fn_q,
   input wire logic o_rom_start_q,
   input wire logic o_safety_core_run_q,
   input wire logic o_low_power_boot_type_q,
   // Pad function codes
   input wire logic [35:0] o_flash_func_q,
   input wire logic [29:0] o_sd1_func_q,
   input wire logic [23:0] o_sd2_func_q,
   input wire logic [14:0] o_first_recovery_serial_port_func_q,
   input wire logic [14:0] o_second_recovery_serial_port_func_q
);
   // One domain, everything quiet while power-on reset is low
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   // Captured word must never move, whatever the pads do later
   AST_CFG_HOLD: assert property (o_cfg_valid_q |=> o_cfg_valid_q && $stable(o_boot_cfg_q))
      else $error("boot config changed after capture");
   AST_FUSE_MODE: assert property ($rose(o_rom_start_q) |->
      o_fuse_mode_q == (o_boot_cfg_q[2:0] == `BSRC_FUSE || $past(i_fuse_override)))
      else $error("fuse mode decode wrong");
   AST_PIN_DEV: assert property ($rose(o_rom_start_q) && !o_fuse_mode_q &&
      o_boot_cfg_q[2:0] inside {[3'h2:3'h5]} |-> o_boot_dev_q == o_boot_cfg_q[2:0])
      else $error("boot device differs from straps");
   AST_DOWNLOAD: assert property ($rose(o_rom_start_q) && !o_fuse_mode_q |->
      o_download_mode_q == (o_boot_cfg_q[2:0] == `BSRC_USB))
      else $error("download mode decode wrong");
   AST_RESERVED: assert property ($rose(o_rom_start_q) && !o_fuse_mode_q &&
      o_boot_cfg_q[2:1] == 2'b11 |-> ##[0:1] o_boot_error_q)
      else $error("reserved code not flagged");
   AST_STRAP_FN: assert property (o_strap_pads_boot_fn_q != o_rom_start_q)
      else $error("strap pad function overlaps rom start");
   AST_LPB: assert property (o_rom_start_q |-> o_safety_core_run_q && o_low_power_boot_type_q)
      else $error("low power boot type not in force");
   AST_DL_IDLE: assert property (o_download_mode_q |->
      {o_flash_func_q, o_sd1_func_q, o_sd2_func_q} == {30{`PAD_FUNC_IDLE}})
      else $error("download mode claimed pads");
   AST_EMMC_PADS: assert property ($rose(o_rom_start_q) && o_boot_dev_q == `BSRC_EMMC &&
      !o_boot_error_q |-> ##[1:3] o_sd1_func_q[20:0] == 21'h0)
      else $error("first card host pads not on function zero");
   AST_FLASH_PADS: assert property ($rose(o_rom_start_q) && !o_boot_error_q &&
      (o_boot_dev_q == `BSRC_NOR || o_boot_dev_q == `BSRC_NAND) |->
      ##[1:3] o_flash_func_q[35:24] == 12'h0)
      else $error("flash control pads not on function zero");
   AST_RECOVERY_PADS: assert property ($rose(o_recovery_q) |-> ##[1:2]
      (o_recovery_port_q ? o_second_recovery_serial_port_func_q : o_first_recovery_serial_port_func_q) == {5{`PAD_FUNC_TWO}})
      else $error("recovery port pads not on function two");

   // Main paths
   CV_FUSE: cover property ($rose(o_rom_start_q) && o_fuse_mode_q);
   CV_DL: cover property ($rose(o_download_mode_q));
   CV_REC: cover property ($rose(o_recovery_q));
   CV_ERR: cover property ($rose(o_boot_error_q));
endmodule

bind boot_mode_select boot_mode_select_props u_boot_mode_select_props (
   .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_fuse_override(i_fuse_override),
   .o_boot_cfg_q(o_boot_cfg_q), .o_cfg_valid_q(o_cfg_valid_q), .o_fuse_mode_q(o_fuse_mode_q),
   .o_boot_dev_q(o_boot_dev_q), .o_download_mode_q(o_download_mode_q),
   .o_recovery_q(o_recovery_q), .o_recovery_port_q(o_recovery_port_q),
   .o_boot_error_q(o_boot_error_q), .o_strap_pads_boot_fn_q(o_strap_pads_boot_fn_q),
   .o_rom_start_q(o_rom_start_q), .o_safety_core_run_q(o_safety_core_run_q),
   .o_low_power_boot_type_q(o_low_power_boot_type_q), .o_flash_func_q(o_flash_func_q),
   .o_sd1_func_q(o_sd1_func_q), .o_sd2_func_q(o_sd2_func_q),
   .o_first_recovery_serial_port_func_q(o_first_recovery_serial_port_func_q), .o_second_recovery_serial_port_func_q(o_second_recovery_serial_port_func_q));
`default_nettype wire

/* File: test/boot_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module boot_board_model (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Strap setting and media failure requests
   input wire logic [3:0] i_strap,
   input wire logic i_fail_primary,
   input wire logic i_fail_recovery,
   // Seen by the device
   output logic [3:0] o_boot_mode_pin,
   output logic o_primary_fail,
   output logic o_recovery_fail
);
   logic [3:0] hold_q;
   logic [3:0] act_q;
   logic fp_q;
   logic fr_q;

   // Edges since release, saturating
   always @(posedge i_core_clk) begin
      if (!i_nrst) begin
         hold_q <= 4'h0;
         act_q <= 4'h5;
      end else begin
         if (hold_q != 4'hf) begin
            hold_q <= hold_q + 4'h1;
         end
         act_q <= act_q + 4'h7;
      end
      fp_q <= i_fail_primary;
      fr_q <= i_fail_recovery;
   end

   // Only pulls act through reset and the sample margin; later the shared pads carry traffic
   assign o_boot_mode_pin = (!i_nrst || hold_q < 4'h8) ? i_strap : act_q;
   // Media report each failure once
   assign o_primary_fail = i_fail_primary & ~fp_q;
   assign o_recovery_fail = i_fail_recovery & ~fr_q;
endmodule
`default_nettype wire

/* File: test/tb_boot_mode_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "boot_mode_regs.vh"
`define CHK(nm, exp, got) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
   end \
end
module tb_boot_mode_select;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] strap = 4'h0;
   logic ovr = 1'b0;
   logic [2:0] fdev = 3'h0;
   logic [1:0] fw = 2'h0;
   logic host1 = 1'b0;
   logic d5 = 1'b0;
   logic rport = 1'b0;
   logic req_p = 1'b0;
   logic req_r = 1'b0;
   wire logic [3:0] pins;
   wire logic pfail, rfail, valid, fmode, dl, rec, rp_q, err, sfn, rom, safe, low_power_boot_type;
   wire logic [3:0] cfg;
   wire logic [2:0] dev;
   wire logic [1:0] width;
   wire logic [35:0] fl;
   wire logic [29:0] s1;
   wire logic [23:0] s2;
   wire logic [14:0] p1, p2;
   int num_errors = 0;
   int comparisons = 0;

   boot_mode_select u_boot_mode_select (.i_core_clk(clk), .i_nrst(nrst), .i_boot_mode_pin(pins),
      .i_fuse_override(ovr), .i_fuse_boot_dev(fdev), .i_fuse_sd_on_host1(host1),
      .i_fuse_sd1_reset_on_d5(d5), .i_fuse_flash_width(fw), .i_fuse_recovery_port(rport),
      .i_primary_fail(pfail), .i_recovery_fail(rfail), .o_boot_cfg_q(cfg),
      .o_cfg_valid_q(valid), .o_fuse_mode_q(fmode), .o_boot_dev_q(dev),
      .o_flash_width_q(width), .o_download_mode_q(dl), .o_recovery_q(rec),
      .o_recovery_port_q(rp_q), .o_boot_error_q(err), .o_strap_pads_boot_fn_q(sfn),
      .o_rom_start_q(rom), .o_safety_core_run_q(safe), .o_low_power_boot_type_q(low_power_boot_type),
      .o_flash_func_q(fl), .o_sd1_func_q(s1), .o_sd2_func_q(s2), .o_first_recovery_serial_port_func_q(p1),
      .o_second_recovery_serial_port_func_q(p2));
   boot_board_model u_boot_board_model (.i_core_clk(clk), .i_nrst(nrst), .i_strap(strap),
      .i_fail_primary(req_p), .i_fail_recovery(req_r), .o_boot_mode_pin(pins),
      .o_primary_fail(pfail), .o_recovery_fail(rfail));

   // Free-running 100 MHz clock
   initial forever #5 clk = ~clk;

   task automatic tally_and_finish();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Sample one step after the edge so its updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Setup word: strap, override, fuse device, width, host1, data5 reset, recovery port
   task automatic boot(input logic [12:0] setup);
      int n;
      @(posedge clk);
      nrst <= 1'b0;
      {strap, ovr, fdev, fw, host1, d5, rport} <= setup;
      {req_p, req_r} <= 2'b00;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      for (n = 0; n < 40 && rom !== 1'b1; n++) tick(1);
      if (rom !== 1'b1) begin
         $display("ERROR rom_start expected 1 seen %h", rom);
         num_errors++;
         tally_and_finish();
      end
      // Let pads settle while the board toggles the shared pins
      tick(12);
      `CHK("strap_fn", 1'b0, sfn)
      `CHK("valid", 1'b1, valid)
      `CHK("safety_core", 1'b1, safe)
      `CHK("low_power", 1'b1, low_power_boot_type)
   endtask

   task automatic t_strap_codes();
      logic [2:0] lo;
      for (int c = 0; c < 16; c++) begin
         lo = c[2:0];
         boot({c[3:0], 1'b0, `BSRC_NOR, `FW_8BIT, 3'b010});
         `CHK("cfg", c[3:0], cfg)
         `CHK("fuse_mode", lo == 3'h0, fmode)
         `CHK("error", lo > 3'h5, err)
         `CHK("download", lo == `BSRC_USB, dl)
         `CHK("spi", {10{3'h7}}, {p2, p1})
         case (lo)
            3'h0, 3'h4, 3'h5: begin
               `CHK("dev", (lo == 3'h0) ? `BSRC_NOR : lo, dev)
               `CHK("flash", 36'h0, fl)
               `CHK("width", `FW_8BIT, width)
            end
            3'h2: `CHK("sd1", {6'h0, 3'h2, 21'h0}, s1)
            3'h3: `CHK("sd2", 24'h0, s2)
            default: `CHK("pads", {30{3'h7}}, {fl, s1, s2})
         endcase
      end
   endtask

   task automatic t_fuse();
      boot({4'hb, 1'b1, `BSRC_NAND, `FW_1BIT, 3'b000});
      `CHK("fuse_mode", 1'b1, fmode)
      `CHK("dev", `BSRC_NAND, dev)
      `CHK("width", `FW_1BIT, width)
      `CHK("flash1", 15'h0, {fl[35:24], fl[2:0]})
      `CHK("sd", {18{3'h7}}, {s1, s2})
      boot({4'hc, 1'b0, 3'h0, `FW_4BIT, 3'b000});
      `CHK("width", `FW_4BIT, width)
      `CHK("flash4", 24'h0, {fl[35:24], fl[11:0]})
      boot({4'h3, 1'b1, `BSRC_SD, `FW_1BIT, 3'b100});
      `CHK("sd1", 18'h0, s1[17:0])
      `CHK("sd2", {8{3'h7}}, s2)
      boot({4'h2, 1'b1, `BSRC_USB, `FW_1BIT, 3'b000});
      `CHK("download", 1'b1, dl)
      `CHK("pads", {40{3'h7}}, {fl, s1, s2, p1, p2})
      boot({4'h2, 1'b0, 3'h0, `FW_1BIT, 3'b000});
      `CHK("sd1", 30'h0, s1)
   endtask

   task automatic t_recovery();
      for (int p = 0; p < 2; p++) begin
         boot({4'h4, 1'b0, 3'h0, `FW_8BIT, 2'b01, p[0]});
         `CHK("rport", p[0], rp_q)
         @(posedge clk);
         req_p <= 1'b1;
         tick(3);
         `CHK("recovery", 1'b1, rec)
         `CHK("flash", {12{3'h7}}, fl)
         `CHK("spi", p ? {{5{3'h2}}, {5{3'h7}}} : {{5{3'h7}}, {5{3'h2}}}, {p2, p1})
         @(posedge clk);
         req_r <= 1'b1;
         tick(3);
         `CHK("error", 1'b1, err)
         `CHK("spi_off", {10{3'h7}}, {p2, p1})
      end
      // A failure report outside primary boot is ignored
      boot({4'h1, 1'b0, 3'h0, `FW_1BIT, 3'b000});
      @(posedge clk);
      req_p <= 1'b1;
      tick(3);
      `CHK("recovery", 1'b0, rec)
   endtask

   // Main sequence
   initial begin
      t_strap_codes();
      t_fuse();
      t_recovery();
      tally_and_finish();
   end
endmodule
`default_nettype wire
